// ===== shared/apm_pkg.sv
`default_nettype none
package apm_pkg;
    // Register indices; byte address is four times the index
    localparam logic [10:0] REG_MON_CTRL   = 11'h270;
    localparam logic [10:0] REG_MON_PERIOD = 11'h271;
    localparam logic [10:0] REG_MON_HOLD   = 11'h274;
    localparam logic [10:0] REG_MON_STAT   = 11'h275;
    localparam logic [10:0] REG_SER_EN_A   = 11'h279;
    localparam logic [10:0] REG_SER_EN_B   = 11'h27A;
    localparam logic [10:0] REG_CB_FN_HI   = 11'h559;
    localparam logic [10:0] REG_CB_FN_LO   = 11'h55A;
    localparam logic [10:0] REG_CB_COUNT   = 11'h58F;
    // Field positions
    localparam int MON_EN_BIT   = 1;
    localparam int SER_EN_B_BIT = 1;
    // Reset values
    localparam logic [7:0]  RST_MON_CTRL   = 8'h00;
    localparam logic [23:0] RST_MON_PERIOD = 24'h000000;
    localparam logic [7:0]  RST_SER_EN     = 8'h00;
    localparam logic [7:0]  RST_CB_FN      = 8'h00;
    localparam logic [7:0]  RST_CB_COUNT   = 8'h00;
    // Control bit function code that carries the monitor stream
    localparam logic [3:0]  CB_FN_MON      = 4'h6;
    // Frame layout
    localparam int FRAME_W     = 25;
    localparam int SUBFRAME_W  = 5;
    localparam int NUM_SUBFR   = 5;
    localparam logic [4:0] FRAME_LAST = 5'h18;
    // Bus answers
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage : apm_pkg
`default_nettype wire

// ===== src/apm_frame_ser.sv
`default_nettype none
module apm_frame_ser
    import apm_pkg::*;
#(
    parameter int PEAK_W = 13
) (
    input  wire logic              core_clk_i,
    input  wire logic              rst_i,
    input  wire logic              load_i,
    input  wire logic [PEAK_W-1:0] peak_i,
    output var  logic              bit_o,
    output var  logic              busy_o
);
    localparam int PAY_W = NUM_SUBFR * (SUBFRAME_W - 1);

    typedef struct packed {
        logic [FRAME_W-1:0] shreg;
        logic [4:0]         left;
        logic               busy;
        logic               bit_out;
    } apm_ser_type;

    apm_ser_type st;
    apm_ser_type next_st;
    logic [PAY_W-1:0]   payload;
    logic [FRAME_W-1:0] frame;

    assign payload = PAY_W'(peak_i);

    // Start bit leads each subframe, four payload bits follow
    always_comb begin
        frame = '0;
        for (int s = 0; s < NUM_SUBFR; s++) begin
            frame[s*SUBFRAME_W + SUBFRAME_W - 1] = 1'b1;
            frame[s*SUBFRAME_W +: SUBFRAME_W-1] = payload[s*(SUBFRAME_W-1) +: SUBFRAME_W-1];
        end
    end

    always_comb begin
        next_st = st;
        if (!st.busy) begin
            next_st.bit_out = 1'b0; // Idle carries zeros
            if (load_i) begin
                next_st.bit_out = frame[FRAME_W-1]; // MSB first
                next_st.shreg   = frame << 1;
                next_st.left    = FRAME_LAST;
                next_st.busy    = 1'b1;
            end
        end else if (st.left != 5'h00) begin
            next_st.bit_out = st.shreg[FRAME_W-1];
            next_st.shreg   = st.shreg << 1;
            next_st.left    = st.left - 5'h01;
        end else begin
            next_st.bit_out = 1'b0;
            next_st.busy    = 1'b0;
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign bit_o  = st.bit_out;
    assign busy_o = st.busy;

    sequence s_start_bits;
        bit_o ##5 bit_o ##5 bit_o ##5 bit_o ##5 bit_o;
    endsequence

    a_start_bits_lead: assert property (@(posedge core_clk_i) disable iff (rst_i)
        load_i && !busy_o |=> s_start_bits)
        else $error("Subframe start bit missing");

    a_idle_zero_out: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !busy_o && !load_i |=> !bit_o)
        else $error("Idle position not zero");
endmodule : apm_frame_ser
`default_nettype wire

// ===== src/apm_signal_monitor.sv
// The placing of the registers and the AXI4-Lite slave port were decided locally.
`default_nettype none
// Summary of operation
// - Track largest sample magnitude per period, sign ignored.
// - Peak result is 13 bits; period is 24 bits of output samples.
// - Peak detection runs only while monitor control bit 1 is set.
// - On enable, period loads into countdown timer; decrements each sample.
// - Each sample, keep larger of input magnitude and hidden stored peak.
// - Stored peak is seeded with current sample magnitude, not zero.
// - At timer count one, copy stored peak to readable holding register.
// - After transfer, reload timer, reseed peak with next sample, continue.
// - Serial output needs serial enable bits 1:0 and second bit 1.
// - Up to three control bits per sample; monitor uses one.
// - Control bits fill from MSB; one bit means MSB position only.
// - Function and count registers route monitor stream into control bits.
// - Peak goes out as 25-bit frame, MSB first, five 5-bit subframes.
// - Every subframe begins with a start bit for receiver checks.
module apm_signal_monitor
    import apm_pkg::*;
#(
    parameter int SAMPLE_W = 14,
    parameter int PEAK_W   = 13,
    parameter int PERIOD_W = 24,
    parameter int ADDR_W   = 13
) (
    input  wire logic                core_clk_i,
    input  wire logic                rst_i,
    input  wire logic [SAMPLE_W-1:0] sample_i,
    output var  logic [2:0]          ctrl_bits_o,
    input  wire logic [ADDR_W-1:0]   axi_awaddr_i,
    input  wire logic                axi_awvalid_i,
    output var  logic                axi_awready_o,
    input  wire logic [31:0]         axi_wdata_i,
    input  wire logic [3:0]          axi_wstrb_i,
    input  wire logic                axi_wvalid_i,
    output var  logic                axi_wready_o,
    output var  logic [1:0]          axi_bresp_o,
    output var  logic                axi_bvalid_o,
    input  wire logic                axi_bready_i,
    input  wire logic [ADDR_W-1:0]   axi_araddr_i,
    input  wire logic                axi_arvalid_i,
    output var  logic                axi_arready_o,
    output var  logic [31:0]         axi_rdata_o,
    output var  logic [1:0]          axi_rresp_o,
    output var  logic                axi_rvalid_o,
    input  wire logic                axi_rready_i
);
    typedef struct packed {
        logic [7:0]          mon_ctrl;
        logic [PERIOD_W-1:0] period;
        logic [7:0]          ser_en_a;
        logic [7:0]          ser_en_b;
        logic [7:0]          cb_fn_hi;
        logic [7:0]          cb_fn_lo;
        logic [7:0]          cb_count;
        logic [PEAK_W-1:0]   hold;
        logic [PEAK_W-1:0]   peak;
        logic [PERIOD_W-1:0] timer;
        logic                running;
        logic                first;
        logic                awready;
        logic                aw_full;
        logic [ADDR_W-3:0]   awidx;
        logic                wready;
        logic                w_full;
        logic [31:0]         wdata;
        logic [3:0]          wstrb;
        logic                bvalid;
        logic [1:0]          bresp;
        logic                arready;
        logic                rvalid;
        logic [31:0]         rdata;
        logic [1:0]          rresp;
        logic [2:0]          cbits;
    } apm_state_type;

    apm_state_type st;
    apm_state_type next_st;

    logic [SAMPLE_W-1:0] neg_sample;
    logic [PEAK_W-1:0]   mag;
    logic [PEAK_W-1:0]   cur;
    logic                run_end;
    logic                ser_en;
    logic                ser_bit;
    logic                ser_load;
    logic [ADDR_W-3:0]   aridx;
    localparam int IDX_W = ADDR_W - 2;

    // Magnitude only; full-scale negative saturates to the top code
    assign neg_sample = sample_i[SAMPLE_W-1] ? SAMPLE_W'(-$signed(sample_i)) : sample_i;
    assign mag = neg_sample[SAMPLE_W-1] ? {PEAK_W{1'b1}} : neg_sample[PEAK_W-1:0];

    // Seed on first sample, otherwise keep the larger
    assign cur = (st.first || mag > st.peak) ? mag : st.peak;

    // Period zero behaves as one so the countdown never wraps
    assign run_end = st.running && (st.timer <= PERIOD_W'(1));

    assign ser_en = (st.ser_en_a[1:0] == 2'h3) && st.ser_en_b[SER_EN_B_BIT];
    // No frame for a period cut short by a disable, so link and holding register agree
    assign ser_load = run_end && ser_en && st.mon_ctrl[MON_EN_BIT];
    assign aridx = axi_araddr_i[ADDR_W-1:2];

    apm_frame_ser #(
        .PEAK_W (PEAK_W)
    ) u_frame_ser (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .load_i     (ser_load),
        .peak_i     (cur),
        .bit_o      (ser_bit),
        .busy_o     ()
    );

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                r[b*8 +: 8] = d[b*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    function automatic logic mapped(input logic [ADDR_W-3:0] idx);
        logic r;
        r = 1'b0;
        case (idx)
            IDX_W'(REG_MON_CTRL), IDX_W'(REG_MON_PERIOD), IDX_W'(REG_MON_HOLD),
            IDX_W'(REG_MON_STAT), IDX_W'(REG_SER_EN_A), IDX_W'(REG_SER_EN_B),
            IDX_W'(REG_CB_FN_HI), IDX_W'(REG_CB_FN_LO), IDX_W'(REG_CB_COUNT): begin
                r = 1'b1;
            end
            default: begin
                r = 1'b0;
            end
        endcase
        return r;
    endfunction : mapped

    always_comb begin
        next_st = st;

        // Write address and data taken in either order
        if (axi_awvalid_i && st.awready) begin
            next_st.aw_full = 1'b1;
            next_st.awidx   = axi_awaddr_i[ADDR_W-1:2];
        end
        if (axi_wvalid_i && st.wready) begin
            next_st.w_full = 1'b1;
            next_st.wdata  = axi_wdata_i;
            next_st.wstrb  = axi_wstrb_i;
        end
        if (st.bvalid && axi_bready_i) begin
            next_st.bvalid = 1'b0;
        end
        if (st.aw_full && st.w_full && !st.bvalid) begin
            next_st.aw_full = 1'b0;
            next_st.w_full  = 1'b0;
            next_st.bvalid  = 1'b1;
            next_st.bresp   = mapped(st.awidx) ? RESP_OKAY : RESP_SLVERR;
            case (st.awidx)
                IDX_W'(REG_MON_CTRL): begin
                    next_st.mon_ctrl = 8'(merge({24'h0, st.mon_ctrl}, st.wdata, st.wstrb));
                end
                IDX_W'(REG_MON_PERIOD): begin
                    next_st.period = PERIOD_W'(merge(32'(st.period), st.wdata, st.wstrb));
                end
                IDX_W'(REG_SER_EN_A): begin
                    next_st.ser_en_a = 8'(merge({24'h0, st.ser_en_a}, st.wdata, st.wstrb));
                end
                IDX_W'(REG_SER_EN_B): begin
                    next_st.ser_en_b = 8'(merge({24'h0, st.ser_en_b}, st.wdata, st.wstrb));
                end
                IDX_W'(REG_CB_FN_HI): begin
                    next_st.cb_fn_hi = 8'(merge({24'h0, st.cb_fn_hi}, st.wdata, st.wstrb));
                end
                IDX_W'(REG_CB_FN_LO): begin
                    next_st.cb_fn_lo = 8'(merge({24'h0, st.cb_fn_lo}, st.wdata, st.wstrb));
                end
                IDX_W'(REG_CB_COUNT): begin
                    next_st.cb_count = 8'(merge({24'h0, st.cb_count}, st.wdata, st.wstrb));
                end
                default: begin
                end
            endcase
        end
        // Ready returns only after the held item is consumed
        next_st.awready = !next_st.aw_full;
        next_st.wready  = !next_st.w_full;

        // Read channel: one outstanding read
        if (st.rvalid && axi_rready_i) begin
            next_st.rvalid  = 1'b0;
            next_st.arready = 1'b1;
        end
        if (axi_arvalid_i && st.arready) begin
            next_st.arready = 1'b0;
            next_st.rvalid  = 1'b1;
            next_st.rresp   = mapped(aridx) ? RESP_OKAY : RESP_SLVERR;
            case (aridx)
                IDX_W'(REG_MON_CTRL):   next_st.rdata = {24'h0, st.mon_ctrl};
                IDX_W'(REG_MON_PERIOD): next_st.rdata = 32'(st.period);
                IDX_W'(REG_MON_HOLD):   next_st.rdata = 32'(st.hold);
                IDX_W'(REG_MON_STAT):   next_st.rdata = {31'h0, st.running};
                IDX_W'(REG_SER_EN_A):   next_st.rdata = {24'h0, st.ser_en_a};
                IDX_W'(REG_SER_EN_B):   next_st.rdata = {24'h0, st.ser_en_b};
                IDX_W'(REG_CB_FN_HI):   next_st.rdata = {24'h0, st.cb_fn_hi};
                IDX_W'(REG_CB_FN_LO):   next_st.rdata = {24'h0, st.cb_fn_lo};
                IDX_W'(REG_CB_COUNT):   next_st.rdata = {24'h0, st.cb_count};
                default:                   next_st.rdata = 32'h0000_0000;
            endcase
        end

        // Peak detector
        if (!st.mon_ctrl[MON_EN_BIT]) begin
            next_st.running = 1'b0;
        end else if (!st.running) begin
            next_st.running = 1'b1;
            next_st.timer   = st.period;
            next_st.first   = 1'b1;
        end else if (run_end) begin
            next_st.hold  = cur;
            next_st.timer = st.period;
            next_st.first = 1'b1;
        end else begin
            next_st.peak  = cur;
            next_st.timer = st.timer - PERIOD_W'(1);
            next_st.first = 1'b0;
        end

        // Control bits filled from MSB; monitor uses one position
        next_st.cbits[2] = ser_en && ser_bit && (st.cb_count[1:0] >= 2'h1)
                           && (st.cb_fn_hi[3:0] == CB_FN_MON);
        next_st.cbits[1] = ser_en && ser_bit && (st.cb_count[1:0] >= 2'h2)
                           && (st.cb_fn_hi[7:4] == CB_FN_MON);
        next_st.cbits[0] = ser_en && ser_bit && (st.cb_count[1:0] == 2'h3)
                           && (st.cb_fn_lo[3:0] == CB_FN_MON);
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st          <= '0;
            st.mon_ctrl <= RST_MON_CTRL;
            st.period   <= RST_MON_PERIOD;
            st.ser_en_a <= RST_SER_EN;
            st.ser_en_b <= RST_SER_EN;
            st.cb_fn_hi <= RST_CB_FN;
            st.cb_fn_lo <= RST_CB_FN;
            st.cb_count <= RST_CB_COUNT;
            st.awready  <= 1'b1;
            st.wready   <= 1'b1;
            st.arready  <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign ctrl_bits_o   = st.cbits;
    assign axi_awready_o = st.awready;
    assign axi_wready_o  = st.wready;
    assign axi_bresp_o   = st.bresp;
    assign axi_bvalid_o  = st.bvalid;
    assign axi_arready_o = st.arready;
    assign axi_rdata_o   = st.rdata;
    assign axi_rresp_o   = st.rresp;
    assign axi_rvalid_o  = st.rvalid;

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);

    logic enabled;
    assign enabled = st.mon_ctrl[MON_EN_BIT];

    sequence s_counting;
        st.running && enabled && !run_end;
    endsequence

    sequence s_period_end;
        st.running && enabled && run_end;
    endsequence

    a_run_needs_en: assert property (
        !enabled |=> !st.running)
        else $error("Detector running while disabled");

    a_start_load_timer: assert property (
        !st.running && enabled |=> st.running && st.first && st.timer == $past(st.period))
        else $error("Timer not loaded at start");

    a_timer_dec_step: assert property (
        s_counting |=> st.timer == $past(st.timer) - PERIOD_W'(1))
        else $error("Timer did not decrement");

    a_peak_keeps_max: assert property (
        s_counting ##0 !st.first |=> st.peak >= $past(st.peak) && st.peak >= $past(mag))
        else $error("Stored peak not the larger value");

    a_seed_with_sample: assert property (
        s_counting ##0 st.first |=> st.peak == $past(mag))
        else $error("Peak not seeded with sample");

    a_hold_on_end: assert property (
        s_period_end |=> st.hold == $past(cur))
        else $error("Holding register not updated");

    a_reload_reseed: assert property (
        s_period_end |=> st.timer == $past(st.period) && st.first)
        else $error("Timer not reloaded");

    a_serial_gate_off: assert property (
        !ser_en |=> ctrl_bits_o == 3'h0)
        else $error("Control bits driven while serial disabled");

    a_msb_only_one: assert property (
        st.cb_count[1:0] == 2'h1 |=> ctrl_bits_o[1:0] == 2'h0)
        else $error("Lower control bit used with count one");

    a_mag_sign_free: assert property (
        sample_i == {{(SAMPLE_W-3){1'b1}}, 3'h3} |-> mag == {{(PEAK_W-3){1'b0}}, 3'h5})
        else $error("Magnitude wrong");

    a_mag_full_scale: assert property (
        sample_i == {1'b1, {(SAMPLE_W-1){1'b0}}} |-> mag == {PEAK_W{1'b1}})
        else $error("Full-scale negative not saturated");

    a_hold_steady: assert property (
        s_counting |=> $stable(st.hold))
        else $error("Holding register changed mid period");

    a_off_hold_kept: assert property (
        !enabled && !st.running |=> $stable(st.hold))
        else $error("Holding register changed while disabled");

    a_seed_clears_first: assert property (
        s_counting |=> !st.first)
        else $error("Seed flag not cleared");

    a_no_count_no_bits: assert property (
        st.cb_count[1:0] == 2'h0 |=> ctrl_bits_o == 3'h0)
        else $error("Control bits driven with count zero");
endmodule : apm_signal_monitor
`default_nettype wire

// ===== verification/apm_link_rx.sv
`default_nettype none
module apm_link_rx (
    input  wire logic        core_clk_i,
    input  wire logic        rst_i,
    input  wire logic        ser_bit_i,
    output var  logic [15:0] frame_cnt_o,
    output var  logic [12:0] peak_o,
    output var  logic [15:0] gap_o,
    output var  logic        err_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [4:0]  cnt;
    logic [23:0] shreg;
    logic [15:0] cyc;
    logic [15:0] last;
    logic [24:0] frame;
    logic [19:0] pay;
    // Deserialize the MSB control bit position, first bit is frame MSB
    assign frame = {shreg, ser_bit_i};
    assign pay   = {frame[23:20], frame[18:15], frame[13:10], frame[8:5], frame[3:0]};
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt         <= 5'h00;
            shreg       <= 24'h000000;
            cyc         <= 16'h0000;
            last        <= 16'h0000;
            frame_cnt_o <= 16'h0000;
            peak_o      <= 13'h0000;
            gap_o       <= 16'h0000;
            err_o       <= 1'b0;
        end else begin
            cyc   <= cyc + 16'h0001;
            shreg <= frame[23:0];
            if (cnt == 5'h00 && ser_bit_i) begin
                // Idle zeros make the first one a frame start
                cnt   <= 5'h01;
                gap_o <= cyc - last;
                last  <= cyc;
            end else if (cnt == 5'h18) begin
                cnt         <= 5'h00;
                frame_cnt_o <= frame_cnt_o + 16'h0001;
                peak_o      <= pay[12:0];
                // Every subframe must open with a one; upper payload empty
                if ({frame[24], frame[19], frame[14], frame[9], frame[4]} != 5'h1F
                    || pay[19:13] != 7'h00) begin
                    err_o <= 1'b1;
                end
            end else if (cnt != 5'h00) begin
                cnt <= cnt + 5'h01;
            end
        end
    end
endmodule : apm_link_rx
`default_nettype wire

// ===== verification/tb.sv
`default_nettype none
module tb
    import apm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk;
    logic        rst;
    logic [13:0] smp;
    logic [2:0]  cb;
    logic [12:0] awaddr;
    logic        awvalid;
    logic        awready;
    logic [31:0] wdata;
    logic        wvalid;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic [12:0] araddr;
    logic        arvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
    logic [15:0] fc;
    logic [15:0] fgap;
    logic [12:0] fpk;
    logic        ferr;
    logic        stray;
    logic [31:0] rd;
    logic [1:0]  rsp;
    logic [15:0] c0;
    int          n_fail;
    int          compares;
    // Small negative baseline so sign handling shows in every result
    localparam logic [13:0] BASE = 14'h3FFB;
    logic [13:0] spk [3] = '{14'h3B2E, 14'h2000, 14'h0FA0};
    logic [12:0] spx [3] = '{13'h04D2, 13'h1FFF, 13'h0FA0};
    logic [10:0] rst_idx [9] = '{REG_MON_CTRL, REG_MON_PERIOD, REG_MON_HOLD, REG_MON_STAT,
        REG_SER_EN_A, REG_SER_EN_B, REG_CB_FN_HI, REG_CB_FN_LO, REG_CB_COUNT};

    apm_signal_monitor u_apm_signal_monitor (
        .core_clk_i(clk), .rst_i(rst), .sample_i(smp), .ctrl_bits_o(cb),
        .axi_awaddr_i(awaddr), .axi_awvalid_i(awvalid), .axi_awready_o(awready),
        .axi_wdata_i(wdata), .axi_wstrb_i(4'hF), .axi_wvalid_i(wvalid),
        .axi_wready_o(wready), .axi_bresp_o(bresp), .axi_bvalid_o(bvalid),
        .axi_bready_i(1'b1), .axi_araddr_i(araddr), .axi_arvalid_i(arvalid),
        .axi_arready_o(arready), .axi_rdata_o(rdata), .axi_rresp_o(rresp),
        .axi_rvalid_o(rvalid), .axi_rready_i(1'b1)
    );
    apm_link_rx u_apm_link_rx (
        .core_clk_i(clk), .rst_i(rst), .ser_bit_i(cb[2]), .frame_cnt_o(fc),
        .peak_o(fpk), .gap_o(fgap), .err_o(ferr)
    );

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // With one control bit the two lower positions must stay silent
    always @(posedge clk) begin
        if (!rst && cb[1:0] !== 2'b00) stray <= 1'b1;
    end

    task automatic end_sim();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_sim
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic tmo(input string what);
        n_fail++;
        $display("mismatch %s expected answer seen timeout", what);
        end_sim();
    endtask : tmo
    // Bus master holds each channel until its own ready; bready stays high
    task automatic wr(input logic [10:0] idx, input logic [31:0] d, output logic [1:0] r);
        int n;
        bit a;
        bit w;
        n = 0;
        a = 0;
        w = 0;
        awaddr  <= {idx, 2'b00};
        awvalid <= 1'b1;
        wdata   <= d;
        wvalid  <= 1'b1;
        forever begin
            @(posedge clk);
            n++;
            if (n > 100) tmo("write");
            if (a && w && bvalid) begin
                r = bresp;
                break;
            end
            if (!a && awready) begin
                a = 1;
                awvalid <= 1'b0;
            end
            if (!w && wready) begin
                w = 1;
                wvalid <= 1'b0;
            end
        end
    endtask : wr
    task automatic rd_reg(input logic [10:0] idx, output logic [31:0] d, output logic [1:0] r);
        int n;
        bit a;
        n = 0;
        a = 0;
        araddr  <= {idx, 2'b00};
        arvalid <= 1'b1;
        forever begin
            @(posedge clk);
            n++;
            if (n > 100) tmo("read");
            if (a && rvalid) begin
                d = rdata;
                r = rresp;
                break;
            end
            if (!a && arready) begin
                a = 1;
                arvalid <= 1'b0;
            end
        end
    endtask : rd_reg
    task automatic wok(input logic [10:0] idx, input logic [31:0] d);
        wr(idx, d, rsp);
        check("bresp", {30'h0, rsp}, {30'h0, RESP_OKAY});
    endtask : wok
    task automatic rchk(input logic [10:0] idx, input logic [31:0] exp, input string what);
        rd_reg(idx, rd, rsp);
        check(what, rd, exp);
        check("rresp", {30'h0, rsp}, {30'h0, RESP_OKAY});
    endtask : rchk
    // Poll the holding register until it leaves prev, then expect exp
    task automatic hold_next(input logic [12:0] prev, input logic [12:0] exp);
        int n;
        n = 0;
        do begin
            rd_reg(REG_MON_HOLD, rd, rsp);
            n++;
            if (n > 40) tmo("hold");
        end while (rd[12:0] === prev);
        check("hold", rd, {19'h0, exp});
    endtask : hold_next
    task automatic link_next(input logic [12:0] exp);
        int n;
        n = 0;
        c0 = fc;
        while (fc === c0) begin
            @(posedge clk);
            n++;
            if (n > 80) tmo("frame");
        end
        check("link peak", {19'h0, fpk}, {19'h0, exp});
        check("link start bits", {31'h0, ferr}, 32'h0);
    endtask : link_next

    initial begin
        rst     = 1'b1;
        smp     = BASE;
        awaddr  = 13'h0000;
        awvalid = 1'b0;
        wdata   = 32'h0;
        wvalid  = 1'b0;
        araddr  = 13'h0000;
        arvalid = 1'b0;
        stray   = 1'b0;
        n_fail  = 0;
        compares = 0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        foreach (rst_idx[i]) rchk(rst_idx[i], 32'h0, "reset value");
        wr(11'h100, 32'h1, rsp);
        check("unmapped bresp", {30'h0, rsp}, {30'h0, RESP_SLVERR});
        rd_reg(11'h100, rd, rsp);
        check("unmapped rresp", {30'h0, rsp}, {30'h0, RESP_SLVERR});
        check("unmapped rdata", rd, 32'h0);
        wok(REG_MON_HOLD, 32'h1FFF);
        rchk(REG_MON_HOLD, 32'h0, "hold read only");
        wok(REG_MON_PERIOD, 32'hFFFFFFFF);
        rchk(REG_MON_PERIOD, 32'h00FFFFFF, "period width");
        wok(REG_MON_PERIOD, 32'h1E);
        wok(REG_CB_FN_HI, {28'h0, CB_FN_MON});
        rchk(REG_CB_FN_HI, {28'h0, CB_FN_MON}, "function");
        wok(REG_CB_COUNT, 32'h1);
        wok(REG_SER_EN_A, 32'h1);
        wok(REG_SER_EN_B, 32'h2);
        wok(REG_MON_CTRL, 32'h2);
        rchk(REG_MON_STAT, 32'h1, "running");
        hold_next(13'h0000, 13'h0005);
        repeat (70) @(posedge clk);
        check("frames half enable", {16'h0, fc}, 32'h0);
        wok(REG_SER_EN_A, 32'h3);
        wok(REG_SER_EN_B, 32'h0);
        repeat (70) @(posedge clk);
        check("frames low enable", {16'h0, fc}, 32'h0);
        wok(REG_SER_EN_B, 32'h2);
        link_next(13'h0005);
        foreach (spk[i]) begin
            smp <= spk[i];
            @(posedge clk);
            smp <= BASE;
            hold_next(13'h0005, spx[i]);
            link_next(spx[i]);
            check("frame spacing", {16'h0, fgap}, 32'h1E);
            hold_next(spx[i], 13'h0005);
        end
        wok(REG_MON_CTRL, 32'h0);
        rchk(REG_MON_STAT, 32'h0, "stopped");
        repeat (30) @(posedge clk);
        c0 = fc;
        smp <= spk[1];
        @(posedge clk);
        smp <= BASE;
        repeat (70) @(posedge clk);
        check("frames when off", {16'h0, fc}, {16'h0, c0});
        rchk(REG_MON_HOLD, 32'h5, "hold when off");
        check("lower positions", {31'h0, stray}, 32'h0);
        end_sim();
    end
endmodule : tb
`default_nettype wire
